// [rtl/three_channel_offset_pwm.sv]
// three channel offset pwm with wishbone register slave
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pwm_regs.svh"
module three_channel_offset_pwm
   import pwm_pkg::*;
#(
   parameter int NCH = 3
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   input  wire logic        auxiliary_pwm_out,
   output logic [NCH-1:0]   primary_channel_out,
   output logic [NCH-1:0]   primary_channel_oe,
   output logic [NCH-1:0]   secondary_channel_out,
   output logic [NCH-1:0]   secondary_channel_oe
);
   generate
      if (NCH != 3) begin : g_bad
         $error("three_channel_offset_pwm: NCH must be 3");
      end
   endgenerate

   // software visible state
   logic [7:0]  block_control;
   logic [15:0] period_value_reg;
   logic [15:0] offset_value;
   logic [15:0] channel_match_value [NCH];
   logic [7:0]  channel_mode_select_low;
   logic [3:0]  channel_mode_select_high;
   logic [5:0]  output_initial_level;

   // active copies used by the compare logic
   logic [15:0] per_act;
   logic [15:0] off_act;
   logic [15:0] cmp_act [NCH];

   logic [15:0] timer;
   logic [15:0] next_timer;
   count_dir_t  dir;
   count_dir_t  next_dir;

   logic        run;
   count_mode_t mode;
   logic        burst_target_select;
   logic        block_commutation_enable;
   logic        burst_invert;
   logic        cnt_tick;
   logic        out_tick;

   logic [7:0]  word_adr;
   logic        wr;
   logic        msel_wr_lo;
   logic        msel_wr_hi;
   logic [31:0] next_rdata;
   logic [11:0] mode_sel;

   logic [NCH-1:0] ch_wr;
   logic [NCH-1:0] prim_act;
   logic [NCH-1:0] sec_act;
   logic [NCH-1:0] prim_match;
   logic [NCH-1:0] sec_match;
   logic [NCH-1:0] prim_wrap;
   logic [NCH-1:0] sec_wrap;
   logic [NCH-1:0] prim_region;
   logic [NCH-1:0] sec_region;
   logic [NCH-1:0] burst_en;
   logic [NCH-1:0] next_prim_out;
   logic [NCH-1:0] next_sec_out;
   logic [16:0]    sec_sum;
   logic [16:0]    off_plus_per;
   logic           carrier;

   assign run  = block_control[`CTRL_RUN];
   assign mode = count_mode_t'(block_control[`CTRL_MODE]);
   assign burst_target_select      = block_control[`CTRL_BTS];
   assign block_commutation_enable = block_control[`CTRL_BLOCK_COMMUTATION_ENABLE];
   assign burst_invert             = block_control[`CTRL_BINV];
   assign mode_sel = {channel_mode_select_high, channel_mode_select_low};

   // bus slave: ack one cycle after the strobe, write lands with ack
   assign word_adr = {wb_adr_i[7:2], 2'b00};
   assign wr       = wb_ack_o && wb_we_i;
   assign msel_wr_lo = wr && word_adr == `REG_MODE_SEL && wb_sel_i[0];
   assign msel_wr_hi = wr && word_adr == `REG_MODE_SEL && wb_sel_i[1];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (word_adr)
         `REG_CTRL:     next_rdata[7:0]  = block_control;
         `REG_PERIOD:   next_rdata[15:0] = period_value_reg;
         `REG_OFFSET:   next_rdata[15:0] = offset_value;
         `REG_MATCH0:   next_rdata[15:0] = channel_match_value[0];
         `REG_MATCH1:   next_rdata[15:0] = channel_match_value[1];
         `REG_MATCH2:   next_rdata[15:0] = channel_match_value[2];
         `REG_MODE_SEL: next_rdata[11:0] = mode_sel;
         `REG_INIT_LVL: next_rdata[5:0]  = output_initial_level;
         `REG_STATUS:   next_rdata[16:0] = {dir, timer};
         default:       next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         wb_dat_o <= next_rdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         block_control <= `CTRL_RESET;
      end else if (ce && wr && word_adr == `REG_CTRL && wb_sel_i[0]) begin
         block_control <= wb_dat_i[7:0];
      end
   end

   // sixteen-bit values are written per byte lane, each lane under its own select bit
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         period_value_reg <= `VALUE_RESET;
         offset_value     <= `VALUE_RESET;
      end else if (ce && wr) begin
         if (word_adr == `REG_PERIOD) begin
            if (wb_sel_i[0]) period_value_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) period_value_reg[15:8] <= wb_dat_i[15:8];
         end
         if (word_adr == `REG_OFFSET) begin
            if (wb_sel_i[0]) offset_value[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) offset_value[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         channel_mode_select_low  <= 8'(`MODE_SEL_RESET);
         channel_mode_select_high <= 4'(`MODE_SEL_RESET >> 8);
         output_initial_level     <= `INIT_LVL_RESET;
      end else if (ce) begin
         if (msel_wr_lo) channel_mode_select_low <= wb_dat_i[7:0];
         if (msel_wr_hi) channel_mode_select_high <= wb_dat_i[11:8];
         if (wr && word_adr == `REG_INIT_LVL && wb_sel_i[0]) begin
            output_initial_level <= wb_dat_i[5:0];
         end
      end
   end

   // timer sequence per count mode
   always_comb begin
      next_timer = timer + 16'h0001;
      next_dir   = dir;
      if (mode == MODE_EDGE) begin
         next_dir = DIR_UP;
         if (timer >= per_act) next_timer = 16'h0000;
      end else if (dir == DIR_UP) begin
         if (timer >= per_act) begin
            // a zero period has no down slope, so stay at zero
            next_timer = (per_act == 16'h0000) ? 16'h0000 : timer - 16'h0001;
            next_dir   = (per_act == 16'h0000) ? DIR_UP : DIR_DOWN;
         end
      end else begin
         next_timer = timer - 16'h0001;
         if (timer <= 16'h0001) begin
            next_timer = 16'h0000;
            next_dir   = DIR_UP;
         end
      end
   end

   // pv+1 counts per period in mode 0, 2*pv in mode 1
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         timer <= 16'h0000;
         dir   <= DIR_UP;
      end else if (ce) begin
         if (!run) begin
            timer <= 16'h0000;
            dir   <= DIR_UP;
         end else if (cnt_tick) begin
            timer <= next_timer;
            dir   <= next_dir;
         end
      end
   end

   // stopped timer tracks the written values, so a first start loads them
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         per_act <= `VALUE_RESET;
         off_act <= `VALUE_RESET;
         for (int i = 0; i < NCH; i++) cmp_act[i] <= `VALUE_RESET;
      end else if (ce) begin
         if (!run || (cnt_tick && next_timer == 16'h0000)) begin
            per_act <= period_value_reg;
            off_act <= offset_value;
            for (int i = 0; i < NCH; i++) begin
               cmp_act[i] <= channel_match_value[i];
            end
         end
      end
   end

   pwm_prescaler #(
      .SEL_W (3)
   ) u_presc (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .ce          (ce),
      .run         (run),
      .presc_sel   (block_control[`CTRL_PRESC_LSB +: 3]),
      .count_tick  (cnt_tick),
      .output_tick (out_tick)
   );

   assign sec_sum      = {1'b0, timer} + {1'b0, off_act};
   assign off_plus_per = {1'b0, off_act} + {1'b0, per_act};
   assign carrier      = auxiliary_pwm_out ^ burst_invert;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         localparam int M = 4 * g;
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               channel_match_value[g] <= `VALUE_RESET;
            end else if (ce && wr && word_adr == 8'(`REG_MATCH0 + 4 * g)) begin
               if (wb_sel_i[0]) channel_match_value[g][7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) channel_match_value[g][15:8] <= wb_dat_i[15:8];
            end
         end

         assign ch_wr[g]      = (g < 2) ? msel_wr_lo : msel_wr_hi;
         assign prim_match[g] = timer == cmp_act[g];
         assign sec_match[g]  = sec_sum == {1'b0, cmp_act[g]};
         // high from the match to the wrap; above period never matches
         assign prim_wrap[g]  = cmp_act[g] == 16'h0000;
         assign sec_wrap[g]   = off_plus_per > {1'b0, cmp_act[g]};
         assign prim_region[g] = timer >= cmp_act[g];
         assign sec_region[g]  = sec_sum >= {1'b0, cmp_act[g]};
         assign burst_en[g]    = mode_sel[M + `MS_BURST];

         // pushed into drive when its mode select byte is written
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               primary_channel_oe[g]   <= 1'b0;
               secondary_channel_oe[g] <= 1'b0;
            end else if (ce && ch_wr[g]) begin
               primary_channel_oe[g]   <= 1'b1;
               secondary_channel_oe[g] <= 1'b1;
            end
         end

         // zero timer is the wrap or the bottom; matches toggle elsewhere
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               prim_act[g] <= 1'b0;
               sec_act[g]  <= 1'b0;
            end else if (ce) begin
               if (ch_wr[g]) begin
                  prim_act[g] <= 1'b0;
                  sec_act[g]  <= 1'b0;
               end else if (out_tick) begin
                  if (!mode_sel[M + `MS_PRIM]) begin
                     prim_act[g] <= 1'b0;
                  end else if (timer == 16'h0000) begin
                     prim_act[g] <= prim_wrap[g];
                  end else if (prim_match[g]) begin
                     prim_act[g] <= ~prim_act[g];
                  end
                  if (!mode_sel[M + `MS_SEC]) begin
                     sec_act[g] <= 1'b0;
                  end else if (timer == 16'h0000) begin
                     sec_act[g] <= sec_wrap[g] && (off_act >= cmp_act[g]);
                  end else if (sec_match[g] && sec_wrap[g]) begin
                     sec_act[g] <= ~sec_act[g];
                  end
               end
            end
         end

         // burst replaces the compare waveform with the gated carrier
         always_comb begin
            next_prim_out[g] = output_initial_level[g] ^ prim_act[g];
            next_sec_out[g]  = output_initial_level[g+3] ^ sec_act[g];
            if (burst_en[g] && !block_commutation_enable) begin
               next_sec_out[g] = sec_region[g] ? carrier
                                 : output_initial_level[g+3];
               if (burst_target_select) begin
                  next_prim_out[g] = prim_region[g] ? carrier
                                     : output_initial_level[g];
               end
            end
            if (!primary_channel_oe[g]) next_prim_out[g] = 1'b1;
            if (!secondary_channel_oe[g]) next_sec_out[g] = 1'b1;
         end

         always_ff @(posedge ref_clk) begin
            if (rst) begin
               primary_channel_out[g]   <= 1'b1;
               secondary_channel_out[g] <= 1'b1;
            end else if (ce) begin
               primary_channel_out[g]   <= next_prim_out[g];
               secondary_channel_out[g] <= next_sec_out[g];
            end
         end
      end
   endgenerate

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_reset_idle;
      $past(rst) |-> primary_channel_out == 3'b111
         && primary_channel_oe == 3'b000 && secondary_channel_oe == 3'b000;
   endproperty
   a_reset_idle : assert property (p_reset_idle)
      else $error("outputs not idle high after reset");

   property p_msel_drive;
      ce && msel_wr_lo |=> primary_channel_oe[1:0] == 2'b11
         && prim_act[1:0] == 2'b00 ##1 (!ce || primary_channel_out[0]
         == output_initial_level[0] || burst_en[0]);
   endproperty
   a_msel_drive : assert property (p_msel_drive)
      else $error("mode select write did not start drive");

   property p_wrap0;
      cnt_tick && mode == MODE_EDGE && run && timer >= per_act
         |=> timer == 16'h0000;
   endproperty
   a_wrap0 : assert property (p_wrap0)
      else $error("mode 0 timer did not restart at zero");

   property p_turn1;
      cnt_tick && mode == MODE_CENTRE && run && dir == DIR_UP
         && per_act != 16'h0000 && timer == per_act
         |=> dir == DIR_DOWN && timer == $past(per_act) - 16'h0001;
   endproperty
   a_turn1 : assert property (p_turn1)
      else $error("mode 1 timer did not turn at period");

   property p_prim_toggle;
      ce && out_tick && mode_sel[`MS_PRIM] && !ch_wr[0]
         && timer != 16'h0000 && prim_match[0]
         |=> prim_act[0] != $past(prim_act[0]);
   endproperty
   a_prim_toggle : assert property (p_prim_toggle)
      else $error("primary did not toggle on match");

   property p_sec_toggle;
      ce && out_tick && mode_sel[`MS_SEC] && !ch_wr[0] && sec_wrap[0]
         && timer != 16'h0000 && sec_match[0]
         |=> sec_act[0] != $past(sec_act[0]);
   endproperty
   a_sec_toggle : assert property (p_sec_toggle)
      else $error("secondary did not toggle on offset match");

   property p_zero_cmp;
      ce && out_tick && mode_sel[8 + `MS_PRIM] && !ch_wr[2]
         && cmp_act[2] == 16'h0000 && (timer == 16'h0000 || prim_act[2])
         |=> prim_act[2];
   endproperty
   a_zero_cmp : assert property (p_zero_cmp)
      else $error("zero compare did not hold primary active");

   property p_reload;
      ce && run && cnt_tick && next_timer == 16'h0000
         |=> per_act == $past(period_value_reg)
         && cmp_act[0] == $past(channel_match_value[0]);
   endproperty
   a_reload : assert property (p_reload)
      else $error("values not reloaded at zero");

   property p_timer_edge;
      !cnt_tick && run |=> $stable(timer);
   endproperty
   a_timer_edge : assert property (p_timer_edge)
      else $error("timer moved without its input clock edge");

   property p_burst_carrier;
      ce && burst_en[0] && !block_commutation_enable
         && secondary_channel_oe[0] && sec_region[0]
         |=> !$past(ce) || secondary_channel_out[0] == $past(carrier);
   endproperty
   a_burst_carrier : assert property (p_burst_carrier)
      else $error("secondary did not carry the burst signal");

   property p_no_wrap_static;
      ce && out_tick && !ch_wr[2] && (timer == 16'h0000 || !sec_act[2])
         && off_plus_per <= {1'b0, cmp_act[2]} |=> !sec_act[2];
   endproperty
   a_no_wrap_static : assert property (p_no_wrap_static)
      else $error("secondary left static level");

   c_turn1 : cover property (cnt_tick && mode == MODE_CENTRE
      && dir == DIR_UP && timer == per_act && per_act != 16'h0000);
   c_burst : cover property (burst_en[0] && sec_region[0]
      && secondary_channel_oe[0] && !block_commutation_enable);
   c_reload : cover property (run && cnt_tick && next_timer == 16'h0000
      && period_value_reg != per_act);
   c_sec_match : cover property (out_tick && sec_match[1]
      && off_act != 16'h0000);
endmodule

// [pkg/pwm_regs.svh]
// register offsets, fields, resets and functional notes for the pwm block
// Functional notes
// - each channel owns primary and secondary out; mode bits pick controlled ones
// - after reset all outputs read high, undriven, weak pull-up only
// - mode select write enables drive and loads the initial level
// - mode 0 timer counts zero to period then restarts at zero
// - mode 0 output toggles on compare match and again at wrap
// - compare zero holds primary at active level permanently
// - compare above period holds primary at its initial level
// - mode 0 wrap sets primary and secondary of each enabled channel back to their zero-time levels
// - primary matches timer, secondary matches timer plus offset
// - offset plus period not above compare keeps secondary static
// - mode 1 counts up to period then down, extremes once
// - mode 1 matches toggle outputs in both count directions
// - compare, period and offset reload when timer reaches zero
// - timer input clock is reference divided by 2 to 256
// - output period is period plus one, or twice period in mode 1
// - burst modulates secondary only, or both by target select
// - per-channel burst bit enables burst on secondary output
// - initial level sets non-modulated level; optional inverted carrier
// - burst works in both modes only while commutation is off
// - burst active while timer plus offset not below compare; on primary while timer not below compare
// - timer advances on first edge, outputs update on second
// - sixteen-bit offset in two bytes shared by all secondaries
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

`define REG_CTRL     8'h00
`define REG_PERIOD   8'h04
`define REG_OFFSET   8'h08
`define REG_MATCH0   8'h0c
`define REG_MATCH1   8'h10
`define REG_MATCH2   8'h14
`define REG_MODE_SEL 8'h18
`define REG_INIT_LVL 8'h1c
`define REG_STATUS   8'h20

`define CTRL_RUN       0
`define CTRL_MODE      1
`define CTRL_PRESC_LSB 2
`define CTRL_BTS       5
`define CTRL_BLOCK_COMMUTATION_ENABLE      6
`define CTRL_BINV      7

`define MS_PRIM  0
`define MS_SEC   1
`define MS_BURST 3

`define CTRL_RESET     8'h00
`define VALUE_RESET    16'h0000
`define MODE_SEL_RESET 12'h000
`define INIT_LVL_RESET 6'h00

`endif

// [pkg/pwm_pkg.sv]
// types shared by the pwm block
package pwm_pkg;
   typedef enum logic [0:0] {
      MODE_EDGE   = 1'b0,
      MODE_CENTRE = 1'b1
   } count_mode_t;
   typedef enum logic [0:0] {
      DIR_UP   = 1'b0,
      DIR_DOWN = 1'b1
   } count_dir_t;
endpackage

// [rtl/pwm_prescaler.sv]
// timer input clock prescaler with two phase ticks
`timescale 1ns/1ps
module pwm_prescaler #(
   parameter int SEL_W = 3
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             run,
   input  wire logic [SEL_W-1:0] presc_sel,
   output logic                  count_tick,
   output logic                  output_tick
);
   localparam int CNT_W = (1 << SEL_W) - 1;

   generate
      if (SEL_W < 1 || SEL_W > 4) begin : g_bad
         $error("pwm_prescaler: SEL_W out of range");
      end
   endgenerate

   logic [CNT_W-1:0] cnt;
   logic [CNT_W:0]   half;
   logic [CNT_W-1:0] half_m1;
   logic             phase;
   logic             edge_due;

   // half period is 2^sel reference clocks, full period 2^(sel+1)
   assign half     = (CNT_W+1)'(1) << presc_sel;
   assign half_m1  = CNT_W'(half - 1'b1);
   assign edge_due = ce && run && (cnt >= half_m1);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt   <= '0;
         phase <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            cnt   <= '0;
            phase <= 1'b0;
         end else if (cnt >= half_m1) begin
            cnt   <= '0;
            phase <= ~phase;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   // rising internal edge clocks the timer, falling edge the outputs
   assign count_tick  = edge_due && !phase;
   assign output_tick = edge_due && phase;

   property p_tick_alt;
      @(posedge ref_clk) disable iff (rst) count_tick |=> !count_tick;
   endproperty
   a_tick_alt : assert property (p_tick_alt)
      else $error("two count ticks back to back");
endmodule

// [testbench/pwm_switch_model.sv]
// power switch bank seen at the six channel pins
`timescale 1ns/1ps
module pwm_switch_bank (
   input  wire logic [2:0] prim_out,
   input  wire logic [2:0] prim_oe,
   input  wire logic [2:0] sec_out,
   input  wire logic [2:0] sec_oe,
   output logic      [5:0] pin_level
);
   // undriven gate inputs sit on the weak pull-up, never hold old levels
   assign pin_level = {(sec_out & sec_oe) | ~sec_oe,
                       (prim_out & prim_oe) | ~prim_oe};
endmodule

// [testbench/tb_three_channel_offset_pwm.sv]
// register-driven tests of the three channel offset pwm
`timescale 1ns/1ps
module tb_three_channel_offset_pwm
   import pwm_pkg::*;
;
   logic        ref_clk, rst, aux, burst_on;
   logic        wb_cyc, wb_stb, wb_we;
   logic [7:0]  wb_adr;
   logic [31:0] wb_dat, wb_q, rq;
   logic [3:0]  wb_sel;
   logic        wb_ack;
   logic [2:0]  p_out, p_oe, s_out, s_oe;
   logic [5:0]  pins;
   int          n_fail, checks, cyc_n, n, tr[6];

   three_channel_offset_pwm u_three_channel_offset_pwm (
      .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .wb_adr_i(wb_adr),
      .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_sel_i(wb_sel),
      .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_ack_o(wb_ack), .auxiliary_pwm_out(aux),
      .primary_channel_out(p_out), .primary_channel_oe(p_oe),
      .secondary_channel_out(s_out), .secondary_channel_oe(s_oe));
   pwm_switch_bank u_pwm_switch_bank (.prim_out(p_out), .prim_oe(p_oe),
      .sec_out(s_out), .sec_oe(s_oe), .pin_level(pins));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // carrier toggles every clock so modulated outputs are easy to spot
   always @(posedge ref_clk) aux <= burst_on & ~aux;
   always @(posedge ref_clk) begin
      cyc_n++;
      if (cyc_n == 60000) begin
         n_fail++;
         give_verdict();
      end
   end

   task give_verdict();
      if (n_fail == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until ack is seen at a rising edge, then released
   task wb(input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_adr <= a;
      wb_dat <= d;
      do @(posedge ref_clk); while (wb_ack !== 1'b1);
      rq = wb_q;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
   endtask
   // clocks between two rising edges of one pin, after a first rise
   task per(input int i, output int m);
      logic p;
      m = 0;
      repeat (2) begin
         m = 0;
         do begin
            p = pins[i];
            @(posedge ref_clk);
            m++;
         end while (!(p === 1'b0 && pins[i] === 1'b1) && m < 5000);
      end
   endtask
   task watch(input int len);
      logic [5:0] p;
      tr = '{default: 0};
      repeat (len) begin
         p = pins;
         @(posedge ref_clk);
         for (int i = 0; i < 6; i++) tr[i] += (p[i] !== pins[i]);
      end
   endtask

   initial begin
      {wb_cyc, wb_stb, wb_we, aux, burst_on} = 5'h00;
      {wb_adr, wb_dat} = 40'h00;
      wb_sel = 4'h3;
      {n_fail, checks, cyc_n} = 0;
      rst = 1'b1;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk(pins, 6'h3f);
      chk({s_oe, p_oe}, 6'h00);
      wb(8'h1c, 32'h2a, 1'b1);
      wb(8'h18, 32'h333, 1'b1);
      repeat (2) @(posedge ref_clk);
      chk({s_oe, p_oe}, 6'h3f);
      chk(pins, 6'h2a);
      wb(8'h24, 32'h0, 1'b0);
      chk(rq, 32'h0);
      wb(8'h20, 32'h0, 1'b0);
      chk(rq, 32'h0);
      wb(8'h1c, 32'h0, 1'b1);
      wb(8'h04, 32'h7, 1'b1);
      wb(8'h08, 32'h2, 1'b1);
      wb(8'h0c, 32'h3, 1'b1);
      wb(8'h10, 32'h5, 1'b1);
      wb(8'h14, 32'h9, 1'b1);
      wb(8'h18, 32'h313, 1'b1);
      for (int s = 0; s < 8; s++) begin
         wb(8'h00, 32'h00, 1'b1);
         wb(8'h00, {s[2:0], 2'b01}, 1'b1);
         per(0, n);
         chk(n, 8 << (s + 1));
      end
      wb(8'h00, 32'h01, 1'b1);
      per(0, n);
      // secondary match leads the primary one by the offset, 2 counts
      n = 0;
      do begin
         rq[5:0] = pins;
         @(posedge ref_clk);
         n++;
      end while (!(pins[3] !== rq[3] && pins[0] === rq[0]) && n < 100);
      n = 0;
      do begin
         rq[5:0] = pins;
         @(posedge ref_clk);
         n++;
      end while (pins[0] === rq[0] && n < 100);
      chk(n, 4);
      watch(32);
      chk(tr[0], 4);
      chk(tr[3], 4);
      chk(tr[4], 0);
      chk({tr[2], tr[5]}, 0);
      chk(pins[2], 1'b0);
      wb(8'h14, 32'h0, 1'b1);
      wb(8'h00, 32'h03, 1'b1);
      per(0, n);
      chk(n, 28);
      watch(28);
      chk(tr[0], 2);
      chk(tr[3], 2);
      chk(tr[2], 0);
      chk(pins[2], 1'b1);
      wb(8'h04, 32'h5, 1'b1);
      // first rise may still belong to the old period
      per(0, n);
      per(0, n);
      chk(n, 20);
      burst_on <= 1'b1;
      wb(8'h18, 32'h31b, 1'b1);
      // mode write clears the waveform state, wait for a clean period
      per(0, n);
      watch(40);
      chk(tr[3] > 8, 1);
      chk(tr[0], 4);
      wb(8'h00, 32'h43, 1'b1);
      per(3, n);
      watch(40);
      chk(tr[3], 4);
      wb(8'h00, 32'h23, 1'b1);
      watch(40);
      chk(tr[0] > 8, 1);
      give_verdict();
   end
endmodule
